// *** logic/hfc_pin_sync.sv ***
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module hfc_pin_sync (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rstn_i,
  // pin and its clean level
  input  wire logic pin_i,
  output logic      level_o
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // shift chain, first stage read only by the second
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // take the level once two stages agree
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      level_o <= 1'b0;
    end else if (s2_r == s3_r) begin
      level_o <= s3_r;
    end
  end

endmodule : hfc_pin_sync

// *** logic/hfc_top.sv ***
// host interrupt enable and feature control registers with status, gating and pin steering
`timescale 1ns/1ps
`include "hfc_regs.svh"

// What this block does
// - both registers clear only on local reset; host reset leaves them alone
// - enable bit 0 lets transfer-done status pull the interrupt low
// - enable bit 1 lets overrun/underrun status pull the interrupt low
// - enable bit 2 lets selection-phase status pull the interrupt low
// - enable bit 4 lets host-reset status pull the interrupt low
// - feature bit 0 holds buffer memory output enable deasserted
// - 16-bit mode with bit 1: master answers drive 0, slave drive 1
// - diagnostic command answered by both drives, status reported by master only
// - feature bit 2 low means master, high means slave
// - feature bit 3 in 16-bit mode turns shared pin into second chip select, else address 9
// - feature bit 4 lets fixed-disk bit 0 gate the host dma channel
// - feature bit 5 reads fixed-disk bit 0 and ignores writes
// - feature bit 6 stops pointer compare until upper stop byte written
// - reading status clears all bits but summary bit 7
// - transfer done sets when stop pointer equals active address pointer
module hfc_top
  import hfc_pkg::*;
(
  // clock and reset
  input  wire logic      clk_sys_i,
  input  wire logic      rstn_i,
  // register port
  input  wire hfc_byte_t reg_addr_i,
  input  wire hfc_byte_t reg_wdata_i,
  input  wire logic      reg_wr_i,
  input  wire logic      reg_rd_i,
  output hfc_byte_t      reg_rdata_o,
  // status event sources
  input  wire logic      overrun_evt_i,
  input  wire logic      sel_phase_evt_i,
  input  wire logic      host_rst_pin_i,
  input  wire logic      fmt_irq_any_i,
  // stop pointer compare
  input  wire hfc_ptr_t  stop_ptr_i,
  input  wire hfc_ptr_t  addr_ptr_i,
  input  wire logic      ptr_active_i,
  input  wire logic      stop_hi_wr_i,
  output logic           stop_cmp_en_o,
  // host mode context
  input  wire logic      at16_mode_i,
  input  wire logic      dma_mode_i,
  input  wire logic      host_dma_en_mirror_i,
  input  wire logic      drive_sel_i,
  input  wire logic      diag_cmd_i,
  // shared host pin
  input  wire logic      shared_pin_i,
  output logic           host_second_chip_sel_n_o,
  output logic           host_addr9_o,
  // buffer memory strobe
  input  wire logic      mem_oe_req_n_i,
  output logic           buffer_mem_out_en_n_o,
  // host side results
  output logic           drive_resp_o,
  output logic           status_report_en_o,
  output logic           host_dma_chan_en_o,
  // interrupt
  output logic           int_n_o
);

  // ************************************************************
  // address decode
  // ************************************************************
  function automatic hfc_sel_t reg_sel(input hfc_byte_t a);
    if (a == `HFC_OFS_STS) begin
      return HFC_SEL_STS;
    end else if (a == `HFC_OFS_IRQ_EN) begin
      return HFC_SEL_EN;
    end else if (a == `HFC_OFS_FEAT) begin
      return HFC_SEL_FEAT;
    end
    return HFC_SEL_NONE;
  endfunction : reg_sel

  logic wr_sts;
  logic wr_en;
  logic wr_feat;
  logic rd_sts;

  assign wr_sts  = reg_wr_i && (reg_sel(reg_addr_i) == HFC_SEL_STS);
  assign wr_en   = reg_wr_i && (reg_sel(reg_addr_i) == HFC_SEL_EN);
  assign wr_feat = reg_wr_i && (reg_sel(reg_addr_i) == HFC_SEL_FEAT);
  assign rd_sts  = reg_rd_i && (reg_sel(reg_addr_i) == HFC_SEL_STS);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [1:0] pin_raw;
  logic [1:0] pin_lvl;
  logic       host_rst_lvl;
  logic       shared_lvl;

  assign pin_raw      = {shared_pin_i, host_rst_pin_i};
  assign host_rst_lvl = pin_lvl[0];
  assign shared_lvl   = pin_lvl[1];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      hfc_pin_sync u_sync (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .pin_i     (pin_raw[gi]),
        .level_o   (pin_lvl[gi])
      );
    end
  endgenerate

  // ************************************************************
  // control registers
  // ************************************************************
  hfc_byte_t en_r;
  hfc_byte_t feat_r;
  hfc_byte_t sts_r;
  hfc_byte_t sts_set;
  hfc_byte_t sts_clr;
  hfc_byte_t sts_nxt;
  hfc_byte_t feat_rd;

  // enable register, reserved bits never stored, only local reset clears
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      en_r <= `HFC_RST_IRQ_EN;
    end else if (wr_en) begin
      en_r <= reg_wdata_i & `HFC_IRQ_EN_MASK;
    end
  end

  // feature register; bit 5 is a live mirror, bit 6 self-clears on stop byte load
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      feat_r <= `HFC_RST_FEAT;
    end else if (wr_feat) begin
      feat_r <= reg_wdata_i & `HFC_FEAT_WR_MASK;
    end else if (stop_hi_wr_i) begin
      feat_r[`HFC_F_CMP_DIS] <= 1'b0;
    end
  end

  assign feat_rd = {feat_r[7:6], host_dma_en_mirror_i, feat_r[4:0]};

  // ************************************************************
  // status flags
  // ************************************************************
  logic cmp_hit;

  assign cmp_hit = ptr_active_i && !feat_r[`HFC_F_CMP_DIS] && (stop_ptr_i == addr_ptr_i);

  // event sets, read clear and write-one clear; a set beats a clear
  always_comb begin
    sts_set                    = 8'h00;
    sts_set[`HFC_B_XFER_DONE]  = cmp_hit;
    sts_set[`HFC_B_OVERRUN]    = overrun_evt_i;
    sts_set[`HFC_B_SEL_PHASE]  = sel_phase_evt_i;
    sts_set[`HFC_B_HOST_RST]   = host_rst_lvl;
    sts_clr                    = rd_sts ? 8'hff : 8'h00;
    if (wr_sts) begin
      sts_clr = sts_clr | reg_wdata_i;
    end
    sts_nxt = ((sts_r & ~sts_clr) | sts_set) & `HFC_IRQ_EN_MASK;
  end

  // sticky status, summary bit kept out of storage
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      sts_r <= `HFC_RST_STS;
    end else begin
      sts_r <= sts_nxt;
    end
  end

  // ************************************************************
  // interrupt output
  // ************************************************************
  // or of gated flags, active low
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      int_n_o <= 1'b1;
    end else begin
      int_n_o <= ~|(sts_nxt & en_r);
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  // data one cycle after the read strobe
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= `HFC_RD_UNMAPPED;
    end else if (reg_rd_i) begin
      unique case (reg_sel(reg_addr_i))
        HFC_SEL_STS:  reg_rdata_o <= {fmt_irq_any_i, sts_r[6:0]};
        HFC_SEL_EN:   reg_rdata_o <= en_r;
        HFC_SEL_FEAT: reg_rdata_o <= feat_rd;
        HFC_SEL_NONE: reg_rdata_o <= `HFC_RD_UNMAPPED;
      endcase
    end
  end

  // ************************************************************
  // feature outputs
  // ************************************************************
  logic ms_on;
  logic is_slave;
  logic drv_match;

  assign ms_on     = at16_mode_i && feat_r[`HFC_F_MS_EN];
  assign is_slave  = feat_r[`HFC_F_MS_SLAVE];
  assign drv_match = (drive_sel_i == is_slave);

  // buffer strobe suppression and pointer compare enable
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      buffer_mem_out_en_n_o <= 1'b1;
      stop_cmp_en_o         <= 1'b1;
    end else begin
      buffer_mem_out_en_n_o <= mem_oe_req_n_i | feat_r[`HFC_F_MEM_OE_DIS];
      stop_cmp_en_o         <= !feat_r[`HFC_F_CMP_DIS];
    end
  end

  // drive response and status report under daisy chaining
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      drive_resp_o       <= 1'b1;
      status_report_en_o <= 1'b1;
    end else if (ms_on) begin
      drive_resp_o       <= diag_cmd_i | drv_match;
      status_report_en_o <= diag_cmd_i ? !is_slave : drv_match;
    end else begin
      drive_resp_o       <= 1'b1;
      status_report_en_o <= 1'b1;
    end
  end

  // shared pin steering
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      host_second_chip_sel_n_o <= 1'b1;
      host_addr9_o             <= 1'b0;
    end else if (at16_mode_i && feat_r[`HFC_F_CS2_MODE]) begin
      host_second_chip_sel_n_o <= shared_lvl;
      host_addr9_o             <= 1'b0;
    end else begin
      host_second_chip_sel_n_o <= 1'b1;
      host_addr9_o             <= shared_lvl;
    end
  end

  // dma channel enable, optionally gated by the fixed-disk bit
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      host_dma_chan_en_o <= 1'b0;
    end else begin
      host_dma_chan_en_o <= at16_mode_i && dma_mode_i &&
                            (!feat_r[`HFC_F_DMA_GATE] || host_dma_en_mirror_i);
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  a_irq_follows: assert property (##1 int_n_o == !(|($past(sts_nxt) & $past(en_r))))
    else $error("interrupt does not follow gated status");
  a_done_irq: assert property (cmp_hit && en_r[0] |=> !int_n_o)
    else $error("transfer done not signalled");
  a_ovr_irq: assert property (overrun_evt_i && en_r[1] |=> !int_n_o)
    else $error("overrun not signalled");
  a_sel_irq: assert property (sel_phase_evt_i && en_r[2] |=> !int_n_o)
    else $error("selection phase not signalled");
  a_rst_irq: assert property (host_rst_lvl && en_r[4] |=> !int_n_o)
    else $error("host reset not signalled");
  a_rsv_zero: assert property ((en_r & 8'he8) == 8'h00)
    else $error("reserved enable bit stored");
  a_rd_clear: assert property (rd_sts && !overrun_evt_i |=> !sts_r[1])
    else $error("status read did not clear");
  a_oe_hold: assert property (feat_r[0] |=> buffer_mem_out_en_n_o)
    else $error("memory output enable not suppressed");
  a_cmp_block: assert property (feat_r[6] && !sts_r[0] && !rd_sts && !wr_sts |=> !sts_r[0])
    else $error("compare not suppressed");
  a_mirror_rd: assert property (reg_rd_i && reg_addr_i == `HFC_OFS_FEAT |=>
                                reg_rdata_o[5] == $past(host_dma_en_mirror_i))
    else $error("mirror bit wrong");
  a_slave_diag: assert property (ms_on && is_slave && diag_cmd_i |=> drive_resp_o && !status_report_en_o)
    else $error("slave reported diagnostic status");
  a_dma_gate: assert property (at16_mode_i && dma_mode_i && feat_r[4] && !host_dma_en_mirror_i
                               |=> !host_dma_chan_en_o)
    else $error("dma channel not gated");

  c_done_irq: cover property (cmp_hit && en_r[0] ##1 !int_n_o);
  c_rd_clear: cover property (!int_n_o ##1 rd_sts ##1 int_n_o);
  c_slave: cover property (ms_on && is_slave && drive_sel_i);
  c_cmp_rearm: cover property (feat_r[6] ##1 stop_hi_wr_i ##1 !feat_r[6]);

endmodule : hfc_top

// *** shared/hfc_pkg.sv ***
// types shared by the host irq / feature block
package hfc_pkg;

  typedef logic [7:0]  hfc_byte_t;
  typedef logic [15:0] hfc_ptr_t;

  // register selected by a bus address
  typedef enum logic [1:0] {
    HFC_SEL_NONE = 2'b00,
    HFC_SEL_STS  = 2'b01,
    HFC_SEL_EN   = 2'b10,
    HFC_SEL_FEAT = 2'b11
  } hfc_sel_t;

endpackage : hfc_pkg

// *** shared/hfc_regs.svh ***
// register offsets, field positions, reset values and masks of the host irq / feature block
`ifndef HFC_REGS_SVH
`define HFC_REGS_SVH

// ************************************************************
// register offsets
// ************************************************************
`define HFC_OFS_STS         8'h50
`define HFC_OFS_IRQ_EN      8'h51
`define HFC_OFS_FEAT        8'h52

// ************************************************************
// status / enable bit positions (shared layout)
// ************************************************************
`define HFC_B_XFER_DONE     0
`define HFC_B_OVERRUN       1
`define HFC_B_SEL_PHASE     2
`define HFC_B_HOST_RST      4
`define HFC_B_SUMMARY       7
`define HFC_IRQ_EN_MASK     8'h17

// ************************************************************
// feature control / status bit positions
// ************************************************************
`define HFC_F_MEM_OE_DIS    0
`define HFC_F_MS_EN         1
`define HFC_F_MS_SLAVE      2
`define HFC_F_CS2_MODE      3
`define HFC_F_DMA_GATE      4
`define HFC_F_DMA_MIRROR    5
`define HFC_F_CMP_DIS       6
`define HFC_F_TEST          7
`define HFC_FEAT_WR_MASK    8'hdf

// ************************************************************
// reset values
// ************************************************************
`define HFC_RST_STS         8'h00
`define HFC_RST_IRQ_EN      8'h00
`define HFC_RST_FEAT        8'h00
`define HFC_RD_UNMAPPED     8'h00

`endif

// *** tb/hfc_mcu_model.sv ***
// microcontroller model that drives the register port of the block
`timescale 1ns/1ps
`include "hfc_regs.svh"
module hfc_mcu_model
  import hfc_pkg::*;
(
  // clock
  input  wire logic      clk_sys_i,
  // register port
  output hfc_byte_t      reg_addr_o,
  output hfc_byte_t      reg_wdata_o,
  output logic           reg_wr_o,
  output logic           reg_rd_o,
  input  wire hfc_byte_t reg_rdata_i
);
  // idle bus at time zero
  initial begin
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
  end
  // one-cycle write; the test bit always goes out as zero
  task automatic wr(input hfc_byte_t a, input hfc_byte_t d);
    @(posedge clk_sys_i);
    reg_addr_o  <= a;
    reg_wdata_o <= (a == `HFC_OFS_FEAT) ? (d & 8'h7f) : d;
    reg_wr_o    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_o    <= 1'b0;
    reg_wdata_o <= ~d;                                     // idle data never echoes the last value
  endtask : wr
  // one-cycle read; data taken once the answer edge has landed
  task automatic rd(input hfc_byte_t a, output hfc_byte_t d);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_rd_o   <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_o   <= 1'b0;
    #1 d = reg_rdata_i;
  endtask : rd
endmodule : hfc_mcu_model

// *** tb/tb_hfc_top.sv ***
// self-checking bench for the host irq enable and feature control block
`timescale 1ns/1ps
module tb_hfc_top
  import hfc_pkg::*;
;
  // ************************************************************
  // signals
  // ************************************************************
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  hfc_byte_t reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, stop_cmp_en, cs2_n, addr9, oe_n, resp, rep, dma_en, int_n;
  logic ovr = 1'b0, selp = 1'b0, hrst = 1'b0, fmt = 1'b0, act = 1'b0, stop_wr = 1'b0;
  logic at16 = 1'b0, dma = 1'b0, mir = 1'b0;
  logic dsel = 1'b0, diag = 1'b0, spin = 1'b0, oe_req_n = 1'b0;
  hfc_ptr_t stop_ptr = 16'h0010, addr_ptr = 16'h0000;
  int n_mismatch = 0, check_count = 0, ticks = 0;
  // clock, 100 MHz
  initial forever #5 clk_sys_i = ~clk_sys_i;
  // ************************************************************
  // design and microcontroller model
  // ************************************************************
  hfc_mcu_model hfc_mcu_model_i (.clk_sys_i(clk_sys_i), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
    .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata));
  hfc_top hfc_top_i (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .overrun_evt_i(ovr),
    .sel_phase_evt_i(selp), .host_rst_pin_i(hrst), .fmt_irq_any_i(fmt), .stop_ptr_i(stop_ptr),
    .addr_ptr_i(addr_ptr), .ptr_active_i(act), .stop_hi_wr_i(stop_wr), .stop_cmp_en_o(stop_cmp_en),
    .at16_mode_i(at16), .dma_mode_i(dma), .host_dma_en_mirror_i(mir), .drive_sel_i(dsel),
    .diag_cmd_i(diag), .shared_pin_i(spin), .host_second_chip_sel_n_o(cs2_n), .host_addr9_o(addr9),
    .mem_oe_req_n_i(oe_req_n), .buffer_mem_out_en_n_o(oe_n), .drive_resp_o(resp),
    .status_report_en_o(rep), .host_dma_chan_en_o(dma_en), .int_n_o(int_n));
  // ************************************************************
  // helpers
  // ************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : cyc
  task automatic chk(input hfc_byte_t got, input hfc_byte_t exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: byte got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chkb(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: bit got %b expected %b", $time, got, exp);
    end
  endtask : chkb
  task automatic rdchk(input hfc_byte_t a, input hfc_byte_t exp);
    hfc_byte_t v;
    hfc_mcu_model_i.rd(a, v);
    chk(v, exp);
  endtask : rdchk
  // raise the status event that sits at bit b
  task automatic fire(input int b);
    @(posedge clk_sys_i);
    case (b)
      0: begin act <= 1'b1; addr_ptr <= stop_ptr; end
      1: ovr <= 1'b1;
      2: selp <= 1'b1;
      default: hrst <= 1'b1;
    endcase
    repeat (b == 4 ? 5 : 1) @(posedge clk_sys_i);
    {act, ovr, selp, hrst} <= 4'h0;
    addr_ptr <= 16'h0000;
    cyc(8);
  endtask : fire
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  // hang guard
  always @(posedge clk_sys_i) begin
    ticks <= ticks + 1;
    if (ticks == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end
  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    int evb[4] = '{0, 1, 2, 4};
    cyc(5);
    rstn_i <= 1'b1;
    cyc(1);
    rdchk(8'h51, 8'h00);
    rdchk(8'h52, 8'h00);
    chkb(int_n, 1'b1);
    rdchk(8'h77, 8'h00);
    hfc_mcu_model_i.wr(8'h51, 8'hff);
    rdchk(8'h51, 8'h17);
    hfc_mcu_model_i.wr(8'h52, 8'hff);
    rdchk(8'h52, 8'h5f);
    mir <= 1'b1;
    cyc(2);
    rdchk(8'h52, 8'h7f);
    mir <= 1'b0;
    hfc_mcu_model_i.wr(8'h52, 8'h1f);         // compare must stay live for the event loop
    $display("test reset and access done");
    // each event masked first, then enabled
    foreach (evb[i]) begin
      hfc_mcu_model_i.wr(8'h51, 8'hff ^ (8'h01 << evb[i]));
      fire(evb[i]);
      chkb(int_n, 1'b1);
      hfc_mcu_model_i.wr(8'h51, 8'h01 << evb[i]);
      cyc(3);
      chkb(int_n, 1'b0);
      rdchk(8'h50, 8'h01 << evb[i]);
      cyc(2);
      chkb(int_n, 1'b1);
      rdchk(8'h50, 8'h00);
    end
    rdchk(8'h51, 8'h10);
    rdchk(8'h52, 8'h1f);
    $display("test interrupt events done");
    // compare held off until upper stop byte written
    hfc_mcu_model_i.wr(8'h51, 8'h01);
    hfc_mcu_model_i.wr(8'h52, 8'h40);
    cyc(2);
    chkb(stop_cmp_en, 1'b0);
    fire(0);
    rdchk(8'h50, 8'h00);
    stop_wr <= 1'b1;
    cyc(1);
    stop_wr <= 1'b0;
    cyc(2);
    chkb(stop_cmp_en, 1'b1);
    rdchk(8'h52, 8'h00);
    act <= 1'b1;
    cyc(2);
    act <= 1'b0;
    rdchk(8'h50, 8'h00);
    fire(0);
    rdchk(8'h50, 8'h01);
    fmt <= 1'b1;
    cyc(1);
    rdchk(8'h50, 8'h80);
    rdchk(8'h50, 8'h80);
    fmt <= 1'b0;
    $display("test stop compare done");
    // feature outputs
    oe_req_n <= 1'b1;
    cyc(2);
    chkb(oe_n, 1'b1);
    oe_req_n <= 1'b0;
    cyc(2);
    chkb(oe_n, 1'b0);
    hfc_mcu_model_i.wr(8'h52, 8'h01);
    cyc(2);
    chkb(oe_n, 1'b1);
    at16 <= 1'b1;
    spin <= 1'b1;
    cyc(6);
    chkb(addr9, 1'b1);
    chkb(cs2_n, 1'b1);
    spin <= 1'b0;
    hfc_mcu_model_i.wr(8'h52, 8'h08);
    cyc(6);
    chkb(cs2_n, 1'b0);
    chkb(addr9, 1'b0);
    hfc_mcu_model_i.wr(8'h52, 8'h02);
    dsel <= 1'b1;
    cyc(2);
    chkb(resp, 1'b0);
    hfc_mcu_model_i.wr(8'h52, 8'h06);
    cyc(2);
    chkb(resp, 1'b1);
    diag <= 1'b1;
    dsel <= 1'b0;
    cyc(2);
    chkb(resp, 1'b1);
    chkb(rep, 1'b0);
    hfc_mcu_model_i.wr(8'h52, 8'h02);
    cyc(2);
    chkb(rep, 1'b1);
    hfc_mcu_model_i.wr(8'h52, 8'h10);
    dma <= 1'b1;
    cyc(2);
    chkb(dma_en, 1'b0);
    mir <= 1'b1;
    cyc(2);
    chkb(dma_en, 1'b1);
    $display("test feature outputs done");
    // local reset in mid-run clears both registers
    rstn_i <= 1'b0;
    cyc(2);
    rstn_i <= 1'b1;
    cyc(1);
    rdchk(8'h51, 8'h00);
    rdchk(8'h52, 8'h20);
    chkb(int_n, 1'b1);
    $display("test local reset done");
    stop_test();
  end
endmodule : tb_hfc_top
